// file: design/bmw_window_decode.sv
// Register bank and range decode for the bridge memory forwarding windows
//
// Local design decision: the Avalon-MM register port.
`timescale 1ns/1ps
// What this block does
// (R1) Forward memory address inside memory window
// (R2) Memory base bits 15:4, writable, reset zero
// (R3) Memory window bottom low bits zero
// (R4) Memory limit bits 31:20, writable, reset zero
// (R5) Memory window top low bits ones
// (R6) Prefetch capability fields read 0001b
// (R7) Forward address inside prefetchable window
// (R8) Prefetch base bits 15:4 writable, reset zero
// (R9) Prefetch limit bits 31:20 writable, reset zero
// (R10) Prefetch base upper 32 bits register
// (R11) Prefetch bottom low 20 bits zero
// (R12) Prefetch limit upper 32 bits register
// (R13) Reserved memory-window bits read zero
module bmw_window_decode
(
    input wire logic CORE_CLK_I,
    input wire logic RST_I,
    // Avalon-MM slave
    input wire bmw_pkg::bmw_av_req_t AV_REQ_I,
    output logic [31:0] AV_READDATA_O,
    output logic AV_WAITREQUEST_O,
    // Address lookup from the forwarding logic
    input wire bmw_pkg::bmw_lookup_t LOOKUP_I,
    output bmw_pkg::bmw_decode_t DECODE_O
);
    import bmw_pkg::*;

    // ==========================================
    // State declarations
    // ==========================================
    logic [11:0] mem_base_q, mem_base_d; // Memory window base [31:20]
    logic [11:0] mem_limit_q, mem_limit_d; // Memory window limit [31:20]
    logic [11:0] pf_base_q, pf_base_d; // Prefetch base [31:20]
    logic [11:0] pf_limit_q, pf_limit_d; // Prefetch limit [31:20]
    logic [31:0] pf_base_hi_q, pf_base_hi_d; // Prefetch base [63:32]
    logic [31:0] pf_limit_hi_q, pf_limit_hi_d; // Prefetch limit [63:32]
    logic [31:0] rdata_q, rdata_d; // Read data
    logic wait_q, wait_d; // Waitrequest
    logic busy_q, busy_d; // Answer cycle in progress
    bmw_decode_t dec_q, dec_d; // Registered decode result

    // Combinational helpers
    logic wr_take; // Write accepted this edge
    logic [31:0] rd_mux; // Register read view
    logic [31:0] wmask; // Byte-lane mask
    logic [31:0] mem_bottom, mem_top; // Full memory window bounds
    logic [63:0] pf_bottom, pf_top; // Full prefetch window bounds

    // ==========================================
    // Bus handshake
    // ==========================================
    // Every request is held one cycle, then answered with waitrequest low.
    // Costs a cycle per access but keeps read data straight from a flop.
    always_comb
    begin
        busy_d = busy_q;
        wait_d = wait_q;
        if (busy_q)
        begin
            // Answer cycle: release
            busy_d = 1'b0;
            wait_d = 1'b1;
        end
        else if (AV_REQ_I.read || AV_REQ_I.write)
        begin
            // New request: answer next cycle
            busy_d = 1'b1;
            wait_d = 1'b0;
        end
    end

    // Write takes effect on the edge where waitrequest is low
    assign wr_take = busy_q && AV_REQ_I.write;

    // Byte enables widened to a bit mask
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            wmask[i*8 +: 8] = {8{AV_REQ_I.byteenable[i]}};
        end
    end

    // ==========================================
    // Register read mux
    // ==========================================
    always_comb
    begin
        rd_mux = BMW_UNMAPPED_RD;
        unique case (AV_REQ_I.address)
            BMW_OFF_MEM_WIN:
            begin
                // Reserved nibbles stay zero
                rd_mux[BMW_BASE_MSB:BMW_BASE_LSB] = mem_base_q; // [R2] [R13]
                rd_mux[BMW_LIMIT_MSB:BMW_LIMIT_LSB] = mem_limit_q; // [R4] [R13]
            end
            BMW_OFF_PF_LOW:
            begin
                rd_mux[BMW_PF_BASE_CAP_LSB +: 4] = BMW_CAP_64BIT; // [R6]
                rd_mux[BMW_BASE_MSB:BMW_BASE_LSB] = pf_base_q; // [R8]
                rd_mux[BMW_PF_LIMIT_CAP_LSB +: 4] = BMW_CAP_64BIT; // [R6]
                rd_mux[BMW_LIMIT_MSB:BMW_LIMIT_LSB] = pf_limit_q; // [R9]
            end
            BMW_OFF_PF_BASE_HI: rd_mux = pf_base_hi_q; // [R10]
            BMW_OFF_PF_LIMIT_HI: rd_mux = pf_limit_hi_q; // [R12]
            default: rd_mux = BMW_UNMAPPED_RD; // Unmapped reads zero
        endcase
    end

    // Read data loaded when the request is first seen
    always_comb
    begin
        rdata_d = rdata_q;
        if (!busy_q && AV_REQ_I.read)
        begin
            rdata_d = rd_mux;
        end
    end

    // ==========================================
    // Register writes
    // ==========================================
    always_comb
    begin
        mem_base_d = mem_base_q;
        mem_limit_d = mem_limit_q;
        pf_base_d = pf_base_q;
        pf_limit_d = pf_limit_q;
        pf_base_hi_d = pf_base_hi_q;
        pf_limit_hi_d = pf_limit_hi_q;
        if (wr_take)
        begin
            unique case (AV_REQ_I.address)
                BMW_OFF_MEM_WIN:
                begin
                    // Only writable fields taken; reserved bits dropped
                    mem_base_d = (mem_base_q & ~wmask[BMW_BASE_MSB:BMW_BASE_LSB])
                        | (AV_REQ_I.writedata[BMW_BASE_MSB:BMW_BASE_LSB] & wmask[BMW_BASE_MSB:BMW_BASE_LSB]); // [R2] [R13]
                    mem_limit_d = (mem_limit_q & ~wmask[BMW_LIMIT_MSB:BMW_LIMIT_LSB])
                        | (AV_REQ_I.writedata[BMW_LIMIT_MSB:BMW_LIMIT_LSB] & wmask[BMW_LIMIT_MSB:BMW_LIMIT_LSB]); // [R4]
                end
                BMW_OFF_PF_LOW:
                begin
                    // Capability nibbles are read-only
                    pf_base_d = (pf_base_q & ~wmask[BMW_BASE_MSB:BMW_BASE_LSB])
                        | (AV_REQ_I.writedata[BMW_BASE_MSB:BMW_BASE_LSB] & wmask[BMW_BASE_MSB:BMW_BASE_LSB]); // [R8] [R6]
                    pf_limit_d = (pf_limit_q & ~wmask[BMW_LIMIT_MSB:BMW_LIMIT_LSB])
                        | (AV_REQ_I.writedata[BMW_LIMIT_MSB:BMW_LIMIT_LSB] & wmask[BMW_LIMIT_MSB:BMW_LIMIT_LSB]); // [R9]
                end
                BMW_OFF_PF_BASE_HI:
                    pf_base_hi_d = (pf_base_hi_q & ~wmask) | (AV_REQ_I.writedata & wmask); // [R10]
                BMW_OFF_PF_LIMIT_HI:
                    pf_limit_hi_d = (pf_limit_hi_q & ~wmask) | (AV_REQ_I.writedata & wmask); // [R12]
                default:
                begin
                    // Unmapped writes ignored
                    mem_base_d = mem_base_q;
                end
            endcase
        end
    end

    // ==========================================
    // Window decode
    // ==========================================
    // Bounds padded to 1 MB granularity
    assign mem_bottom = {mem_base_q, BMW_LOW_ZERO}; // [R3]
    assign mem_top = {mem_limit_q, BMW_LOW_ONES}; // [R5]
    assign pf_bottom = {pf_base_hi_q, pf_base_q, BMW_LOW_ZERO}; // [R11] [R8]
    assign pf_top = {pf_limit_hi_q, pf_limit_q, BMW_LOW_ONES}; // [R9] [R12]

    // Registered compare; a window with base above limit matches nothing.
    // Memory window covers only 32-bit addresses, upper bits must be zero.
    always_comb
    begin
        dec_d.mem_hit = LOOKUP_I.valid && (LOOKUP_I.addr[63:32] == 32'h0000_0000)
            && (LOOKUP_I.addr[31:0] >= mem_bottom) && (LOOKUP_I.addr[31:0] <= mem_top); // [R1]
        dec_d.pf_hit = LOOKUP_I.valid && (LOOKUP_I.addr >= pf_bottom)
            && (LOOKUP_I.addr <= pf_top); // [R7]
        dec_d.forward = dec_d.mem_hit || dec_d.pf_hit; // [R1] [R7]
    end

    // ==========================================
    // Registers
    // ==========================================
    always_ff @(posedge CORE_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            mem_base_q <= BMW_FIELD_RST;
            mem_limit_q <= BMW_FIELD_RST;
            pf_base_q <= BMW_FIELD_RST;
            pf_limit_q <= BMW_FIELD_RST;
            pf_base_hi_q <= BMW_UPPER_RST;
            pf_limit_hi_q <= BMW_UPPER_RST;
            rdata_q <= BMW_UNMAPPED_RD;
            wait_q <= 1'b1;
            busy_q <= 1'b0;
            dec_q <= '0;
        end
        else
        begin
            mem_base_q <= mem_base_d;
            mem_limit_q <= mem_limit_d;
            pf_base_q <= pf_base_d;
            pf_limit_q <= pf_limit_d;
            pf_base_hi_q <= pf_base_hi_d;
            pf_limit_hi_q <= pf_limit_hi_d;
            rdata_q <= rdata_d;
            wait_q <= wait_d;
            busy_q <= busy_d;
            dec_q <= dec_d;
        end
    end

    // Outputs straight from flops
    assign AV_READDATA_O = rdata_q;
    assign AV_WAITREQUEST_O = wait_q;
    assign DECODE_O = dec_q;

    // ==========================================
    // Assertions
    // ==========================================
    property p_mem_fwd;
        @(posedge CORE_CLK_I) disable iff (RST_I)
        (LOOKUP_I.valid && LOOKUP_I.addr[63:32] == 32'h0 && LOOKUP_I.addr[31:20] >= mem_base_q
            && LOOKUP_I.addr[31:20] <= mem_limit_q) |=> DECODE_O.mem_hit && DECODE_O.forward;
    endproperty
    a_mem_fwd: assert property (p_mem_fwd) else $error("memory window hit missed"); // [R1]

    property p_mem_base_wr;
        @(posedge CORE_CLK_I) disable iff (RST_I)
        (wr_take && AV_REQ_I.address == BMW_OFF_MEM_WIN && AV_REQ_I.byteenable == 4'hf)
            |=> mem_base_q == $past(AV_REQ_I.writedata[15:4]);
    endproperty
    a_mem_base_wr: assert property (p_mem_base_wr) else $error("memory base not written"); // [R2]

    property p_mem_bottom;
        @(posedge CORE_CLK_I) disable iff (RST_I)
        (LOOKUP_I.valid && LOOKUP_I.addr == {32'h0, mem_base_q, 20'h0_0000} && mem_base_q <= mem_limit_q)
            |=> DECODE_O.mem_hit;
    endproperty
    a_mem_bottom: assert property (p_mem_bottom) else $error("memory bottom not 1 MB aligned"); // [R3]

    property p_mem_limit_wr;
        @(posedge CORE_CLK_I) disable iff (RST_I)
        (wr_take && AV_REQ_I.address == BMW_OFF_MEM_WIN && AV_REQ_I.byteenable == 4'hf)
            |=> mem_limit_q == $past(AV_REQ_I.writedata[31:20]);
    endproperty
    a_mem_limit_wr: assert property (p_mem_limit_wr) else $error("memory limit not written"); // [R4]

    property p_mem_top;
        @(posedge CORE_CLK_I) disable iff (RST_I)
        (LOOKUP_I.valid && LOOKUP_I.addr == {32'h0, mem_limit_q, 20'hf_ffff} && mem_base_q <= mem_limit_q)
            |=> DECODE_O.mem_hit;
    endproperty
    a_mem_top: assert property (p_mem_top) else $error("memory top not at block end"); // [R5]

    property p_pf_cap;
        @(posedge CORE_CLK_I) disable iff (RST_I)
        (!busy_q && AV_REQ_I.read && AV_REQ_I.address == BMW_OFF_PF_LOW)
            |=> !AV_WAITREQUEST_O && AV_READDATA_O[3:0] == 4'h1 && AV_READDATA_O[19:16] == 4'h1;
    endproperty
    a_pf_cap: assert property (p_pf_cap) else $error("prefetch capability code wrong"); // [R6]

    property p_pf_fwd;
        @(posedge CORE_CLK_I) disable iff (RST_I)
        (LOOKUP_I.valid && LOOKUP_I.addr >= pf_bottom && LOOKUP_I.addr <= pf_top) |=> DECODE_O.pf_hit;
    endproperty
    a_pf_fwd: assert property (p_pf_fwd) else $error("prefetch window hit missed"); // [R7]

    property p_pf_base_hi;
        @(posedge CORE_CLK_I) disable iff (RST_I)
        (wr_take && AV_REQ_I.address == BMW_OFF_PF_BASE_HI && AV_REQ_I.byteenable == 4'hf)
            |=> pf_base_hi_q == $past(AV_REQ_I.writedata) && pf_bottom[63:32] == pf_base_hi_q;
    endproperty
    a_pf_base_hi: assert property (p_pf_base_hi) else $error("prefetch base upper not written"); // [R10]

    property p_rsvd;
        @(posedge CORE_CLK_I) disable iff (RST_I)
        (!busy_q && AV_REQ_I.read && AV_REQ_I.address == BMW_OFF_MEM_WIN)
            |=> AV_READDATA_O[3:0] == 4'h0 && AV_READDATA_O[19:16] == 4'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero"); // [R13]

    // Full-lane write to the low prefetch word moves both fields
    property p_pf_low_wr;
        @(posedge CORE_CLK_I) disable iff (RST_I)
        (wr_take && AV_REQ_I.address == BMW_OFF_PF_LOW && AV_REQ_I.byteenable == 4'hf)
            |=> pf_base_q == $past(AV_REQ_I.writedata[15:4]) && pf_limit_q == $past(AV_REQ_I.writedata[31:20]);
    endproperty
    a_pf_low_wr: assert property (p_pf_low_wr) else $error("prefetch base or limit not written"); // [R8] [R9]

    // Upper limit half is a plain 32-bit register
    property p_pf_limit_hi;
        @(posedge CORE_CLK_I) disable iff (RST_I)
        (wr_take && AV_REQ_I.address == BMW_OFF_PF_LIMIT_HI && AV_REQ_I.byteenable == 4'hf)
            |=> pf_limit_hi_q == $past(AV_REQ_I.writedata);
    endproperty
    a_pf_limit_hi: assert property (p_pf_limit_hi) else $error("prefetch limit upper not written"); // [R12]

    // Lowest byte of a legal prefetch window must hit
    property p_pf_bottom;
        @(posedge CORE_CLK_I) disable iff (RST_I)
        (LOOKUP_I.valid && LOOKUP_I.addr == {pf_base_hi_q, pf_base_q, 20'h0_0000} && pf_bottom <= pf_top)
            |=> DECODE_O.pf_hit;
    endproperty
    a_pf_bottom: assert property (p_pf_bottom) else $error("prefetch bottom not 1 MB aligned"); // [R11]

    c_write: cover property (@(posedge CORE_CLK_I) disable iff (RST_I) wr_take);
    c_mem_hit: cover property (@(posedge CORE_CLK_I) disable iff (RST_I) DECODE_O.mem_hit);
    c_pf_hit: cover property (@(posedge CORE_CLK_I) disable iff (RST_I) DECODE_O.pf_hit);
    c_cap_read: cover property (@(posedge CORE_CLK_I) disable iff (RST_I)
        busy_q && AV_REQ_I.read && AV_REQ_I.address == BMW_OFF_PF_LOW);
endmodule

// file: common/bmw_pkg.sv
// Package for the bridge memory window decode block: offsets, fields, resets, carriers
package bmw_pkg;

    // ==========================================
    // Register offsets (byte addresses)
    // ==========================================
    localparam logic [7:0] BMW_OFF_MEM_WIN = 8'h20; // Memory base/limit doubleword
    localparam logic [7:0] BMW_OFF_PF_LOW = 8'h24; // Prefetch base/limit low doubleword
    localparam logic [7:0] BMW_OFF_PF_BASE_HI = 8'h28; // Prefetch base upper 32 bits
    localparam logic [7:0] BMW_OFF_PF_LIMIT_HI = 8'h2c; // Prefetch limit upper 32 bits

    // ==========================================
    // Field positions
    // ==========================================
    localparam int BMW_BASE_LSB = 4; // Base field bits 15:4
    localparam int BMW_BASE_MSB = 15;
    localparam int BMW_LIMIT_LSB = 20; // Limit field bits 31:20
    localparam int BMW_LIMIT_MSB = 31;
    localparam int BMW_PF_BASE_CAP_LSB = 0; // Capability code bits 3:0
    localparam int BMW_PF_LIMIT_CAP_LSB = 16; // Capability code bits 19:16
    localparam int BMW_GRAN_BITS = 20; // 1 MB granularity

    // ==========================================
    // Values after reset and fixed codes
    // ==========================================
    localparam logic [11:0] BMW_FIELD_RST = 12'h000; // Base/limit fields
    localparam logic [31:0] BMW_UPPER_RST = 32'h0000_0000; // Upper halves
    localparam logic [3:0] BMW_CAP_64BIT = 4'h1; // 64-bit addressing code
    localparam logic [19:0] BMW_LOW_ZERO = 20'h0_0000; // Bottom low bits
    localparam logic [19:0] BMW_LOW_ONES = 20'hf_ffff; // Top low bits
    localparam logic [31:0] BMW_UNMAPPED_RD = 32'h0000_0000; // Unmapped read data

    // Avalon read latency in cycles from request to waitrequest low
    localparam int BMW_RD_WAIT_CYCLES = 1;

    // ==========================================
    // Carriers
    // ==========================================
    typedef struct packed
    {
        logic read;
        logic write;
        logic [7:0] address;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } bmw_av_req_t;

    typedef struct packed
    {
        logic [63:0] addr;
        logic valid;
    } bmw_lookup_t;

    typedef struct packed
    {
        logic mem_hit;
        logic pf_hit;
        logic forward;
    } bmw_decode_t;

endpackage

// file: dv/bmw_window_decode_test.sv
// Self-checking testbench for the bridge memory window decode block
`timescale 1ns/1ps
module bmw_window_decode_test;
    import bmw_pkg::*;

    // ==========================================
    // Stimulus and observed signals
    // ==========================================
    logic core_clk = 1'b0; // 40 MHz core clock
    logic rst = 1'b1; // Active-high reset
    bmw_av_req_t av_req = '0; // Register bus request
    bmw_lookup_t lookup = '0; // Address under test
    logic [31:0] av_rdata; // Read data from the block
    logic av_wait; // Waitrequest from the block
    bmw_decode_t decode; // Window hit flags
    int fail_count = 0; // Mismatches seen
    int checks_done = 0; // Comparisons made
    // Register image kept by the bench
    logic [11:0] m_base = 12'h000;
    logic [11:0] m_lim = 12'h000;
    logic [11:0] p_base = 12'h000;
    logic [11:0] p_lim = 12'h000;
    logic [31:0] b_hi = 32'h0000_0000;
    logic [31:0] l_hi = 32'h0000_0000;

    bmw_window_decode bmw_window_decode_inst
    (
        .CORE_CLK_I(core_clk),
        .RST_I(rst),
        .AV_REQ_I(av_req),
        .AV_READDATA_O(av_rdata),
        .AV_WAITREQUEST_O(av_wait),
        .LOOKUP_I(lookup),
        .DECODE_O(decode)
    );

    // Free-running clock, 25 ns period
    initial
    begin
        forever #12.5 core_clk = ~core_clk;
    end

    // ==========================================
    // Expectations
    // ==========================================
    // Readback image; reserved bits zero, capability nibbles fixed at 1
    function automatic logic [31:0] exp_rd(input logic [7:0] a);
        if (a == BMW_OFF_MEM_WIN) return {m_lim, 4'h0, m_base, 4'h0};
        if (a == BMW_OFF_PF_LOW) return {p_lim, 4'h1, p_base, 4'h1};
        if (a == BMW_OFF_PF_BASE_HI) return b_hi;
        if (a == BMW_OFF_PF_LIMIT_HI) return l_hi;
        return 32'h0000_0000;
    endfunction

    // Hit flags: memory window needs upper half zero, prefetch compares all 64 bits
    function automatic logic [2:0] exp_dec(input logic [63:0] a, input logic v);
        logic mh;
        logic ph;
        mh = (a[63:32] == 32'h0) && (a[31:0] >= {m_base, 20'h0_0000}) && (a[31:0] <= {m_lim, 20'hf_ffff});
        ph = (a >= {b_hi, p_base, 20'h0_0000}) && (a <= {l_hi, p_lim, 20'hf_ffff});
        return v ? {mh, ph, mh | ph} : 3'h0;
    endfunction

    // ==========================================
    // Shared tasks
    // ==========================================
    task automatic wrap_up();
        if (fail_count == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One Avalon access; request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [3:0] be, input logic [31:0] wd,
                       output logic [31:0] rd);
        int n;
        @(posedge core_clk);
        av_req <= '{read: !wr, write: wr, address: a, byteenable: be, writedata: wd};
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (av_wait !== 1'b0 && n < 50);
        rd = av_rdata;
        av_req <= '0;
        // A slave that never answers ends the run
        if (n >= 50)
        begin
            fail_count++;
            $display("wrong value at %0t: waitrequest %h expected %h", $time, av_wait, 1'b0);
            wrap_up();
        end
    endtask

    // Write with lane masking mirrored into the bench image
    task automatic wr_reg(input logic [7:0] a, input logic [3:0] be, input logic [31:0] wd);
        logic [31:0] m;
        logic [31:0] v;
        logic [31:0] rd;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        v = (exp_rd(a) & ~m) | (wd & m);
        bus(1'b1, a, be, wd, rd);
        if (a == BMW_OFF_MEM_WIN) {m_lim, m_base} = {v[31:20], v[15:4]};
        if (a == BMW_OFF_PF_LOW) {p_lim, p_base} = {v[31:20], v[15:4]};
        if (a == BMW_OFF_PF_BASE_HI) b_hi = v;
        if (a == BMW_OFF_PF_LIMIT_HI) l_hi = v;
    endtask

    task automatic rd_chk(input logic [7:0] a);
        logic [31:0] rd;
        bus(1'b0, a, 4'hf, 32'h0000_0000, rd);
        chk({32'h0, rd}, {32'h0, exp_rd(a)});
    endtask

    // Present one lookup, check the flags two cycles later
    task automatic look(input logic [63:0] a, input logic v);
        @(posedge core_clk);
        lookup <= '{addr: a, valid: v};
        @(posedge core_clk);
        @(posedge core_clk);
        chk({61'h0, decode}, {61'h0, exp_dec(a, v)});
    endtask

    // Both edges of both windows, the edge address itself and one step outside
    task automatic corners();
        logic [63:0] lo_m;
        logic [63:0] hi_m;
        logic [63:0] lo_p;
        logic [63:0] hi_p;
        logic [63:0] pts [8];
        lo_m = {32'h0, m_base, 20'h0_0000};
        hi_m = {32'h0, m_lim, 20'hf_ffff};
        lo_p = {b_hi, p_base, 20'h0_0000};
        hi_p = {l_hi, p_lim, 20'hf_ffff};
        pts = '{lo_m, lo_m - 64'h1, hi_m, hi_m + 64'h1, lo_p, lo_p - 64'h1, hi_p, hi_p + 64'h1};
        foreach (pts[i]) look(pts[i], 1'b1);
    endtask

    // ==========================================
    // Main sequence
    // ==========================================
    initial
    begin
        logic [7:0] offs [6];
        offs = '{8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h00};
        void'($urandom(32'h68e2a209));
        repeat (6) @(posedge core_clk);
        chk({60'h0, av_wait, decode}, 64'h8); // Idle bus and no hits while in reset
        rst <= 1'b0;
        // Values after reset, unmapped places included
        foreach (offs[i]) rd_chk(offs[i]);
        corners();
        // All ones everywhere: reserved and fixed bits must not move
        foreach (offs[i]) wr_reg(offs[i], 4'hf, 32'hffff_ffff);
        foreach (offs[i]) rd_chk(offs[i]);
        corners();
        // Random windows with random lanes, including inverted bounds
        repeat (40)
        begin
            wr_reg(BMW_OFF_MEM_WIN, 4'($urandom), $urandom);
            wr_reg(BMW_OFF_PF_LOW, 4'($urandom), $urandom);
            wr_reg(BMW_OFF_PF_BASE_HI, 4'($urandom), $urandom_range(2));
            wr_reg(BMW_OFF_PF_LIMIT_HI, 4'($urandom), $urandom_range(2));
            rd_chk(BMW_OFF_MEM_WIN);
            rd_chk(BMW_OFF_PF_LOW);
            corners();
            look({$urandom_range(2), $urandom}, 1'b1);
            look({$urandom, $urandom}, 1'b0);
        end
        // Reset again mid-run: every field must fall back to zero
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        {m_base, m_lim, p_base, p_lim, b_hi, l_hi} = 112'h0;
        foreach (offs[i]) rd_chk(offs[i]);
        corners();
        wrap_up();
    end
endmodule
